// ---- power_mode_map.vh ----
// Purpose: shared constants of the power mode sequencer
// Assumes: core clock of 200 MHz
// Notes: times are kept in their own unit, cycle counts derived
`ifndef POWER_MODE_MAP_VH
`define POWER_MODE_MAP_VH

// ****************************************
// clock and times
// ****************************************
`define CLK_MHZ 200
`define TOPO_TIMEOUT_US 120
`define TOPO_TIMEOUT_CYC (`TOPO_TIMEOUT_US * `CLK_MHZ)
`define RST_SHORT_US 1000
`define RST_SHORT_CYC (`RST_SHORT_US * `CLK_MHZ)
`define RST_MID_US 10000
`define RST_MID_CYC (`RST_MID_US * `CLK_MHZ)
`define RST_LONG_US 20000
`define RST_LONG_CYC (`RST_LONG_US * `CLK_MHZ)
`define INIT_WIN_US 256000
`define INIT_WIN_CYC (`INIT_WIN_US * `CLK_MHZ)

// ****************************************
// wake edge modes
// ****************************************
`define WAKE_RISE 2'h0
`define WAKE_FALL 2'h1
`define WAKE_ANY 2'h2

// ****************************************
// analog monitor sources and reset values
// ****************************************
`define AMON_REF 1'h0
`define AMON_TEMP 1'h1
`define RST_DUR_SEL_RESET 1'h0

`endif

// ---- io_wake_detect.v ----
// Purpose: wake event detector for one multipurpose IO
// Assumes: pin level synchronous to the clock
// Notes: one-cycle pulse on the configured edge
`timescale 1ns/1ps
`include "power_mode_map.vh"

module io_wake_detect #(
  parameter RESET_LEVEL = 1'b0
) (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // pin and config
  input wire pinIn,
  input wire wakeEn,
  input wire [1:0] wakeMode,
  // event
  output wire wakePulse
);

  reg prev_r;
  reg hit;

  // previous level, reference for edge and change modes
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= RESET_LEVEL;
    end else begin
      prev_r <= pinIn;
    end
  end

  always @* begin
    case (wakeMode)
      `WAKE_RISE: hit = pinIn & ~prev_r;
      `WAKE_FALL: hit = ~pinIn & prev_r;
      `WAKE_ANY: hit = pinIn ^ prev_r;
      default: hit = 1'b0;
    endcase
  end

  assign wakePulse = wakeEn & hit;

endmodule

// ---- power_mode_sequencer.v ----
// Purpose: main power mode and fail-safe output sequencer
// Assumes: comparator results arrive as synchronous digital levels
// Notes: regulator enables are levels to the analog blocks
`timescale 1ns/1ps
`include "power_mode_map.vh"

module power_mode_sequencer #(
  parameter NUM_IO = 6,
  parameter TOPO_CYC = `TOPO_TIMEOUT_CYC,
  parameter RST_SHORT_CYC = `RST_SHORT_CYC,
  parameter RST_MID_CYC = `RST_MID_CYC,
  parameter RST_LONG_CYC = `RST_LONG_CYC,
  parameter INIT_WIN_CYC = `INIT_WIN_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // analog sense results
  input wire gateAbove120mV,
  input wire preSoftDone,
  input wire selectToPre,
  input wire regsRampDone,
  input wire debugInWindow,
  input wire fbDeltaOver150mV,
  // pins from the MCU side
  input wire [NUM_IO-1:0] ioIn,
  input wire canWake,
  // decoded SPI commands
  input wire ampSelWr,
  input wire ampSelData,
  input wire resetDurWr,
  input wire resetDurData,
  input wire initIntWr,
  input wire sleepCmdSecured,
  input wire fsReleaseWr,
  // watchdog results
  input wire wdGoodRefresh,
  input wire wdBadRefresh,
  // external fault requests
  input wire faultToFailsafe,
  input wire faultToReset,
  // IO configuration
  input wire [NUM_IO-1:0] ioWakeEn,
  input wire [2*NUM_IO-1:0] ioWakeMode,
  input wire canWakeEn,
  input wire safePair01En,
  input wire safePair45En,
  input wire safeFbEn,
  input wire safePair23En,
  // regulator and pin controls
  output reg gateTestEn,
  output reg preRegEn,
  output reg coreRegEn,
  output reg auxRegEn,
  output reg anaRegEn,
  output reg xcvrSupplyEn,
  output reg canForceNormal,
  output reg analogMonitorSel,
  output reg failsafe_output_n,
  output reg mcu_reset_n,
  // status
  output reg buckBoost,
  output reg debugMode,
  output reg initLocked,
  output reg resetDurSel,
  output reg [NUM_IO:0] wakeSource,
  output reg [3:0] mainState,
  output reg [1:0] fsState
);

  // ****************************************
  // state codes
  // ****************************************
  localparam M_TOPO = 4'h0;
  localparam M_PRE = 4'h1;
  localparam M_SELECT = 4'h2;
  localparam M_REGON = 4'h3;
  localparam M_RSTLOW = 4'h4;
  localparam M_INIT = 4'h5;
  localparam M_NORMAL = 4'h6;
  localparam M_SLEEP = 4'h7;
  localparam FS_INIT = 2'h0;
  localparam FS_NORMWD = 2'h1;
  localparam FS_RSTDLY = 2'h2;
  localparam FS_OFF = 2'h3;

  // ****************************************
  // declarations
  // ****************************************
  reg [3:0] main_r;
  reg [3:0] main_nxt;
  reg [1:0] fs_r;
  reg [31:0] cnt_r;
  reg [31:0] fsCnt_r;
  reg buckBoost_r;
  reg auxOff_r;
  reg debug_r;
  reg debugTaken_r;
  reg rstLong_r;
  reg fsLow_r;
  reg fsReleased_r;
  reg lock_r;
  reg durSel_r;
  reg ampSel_r;
  reg [NUM_IO:0] wakeSrc_r;
  wire [NUM_IO-1:0] ioWake;
  wire anyWake;
  wire safetyFault;
  wire pair01Err;
  wire pair45Err;
  wire pair23Err;
  wire wdFault;
  wire rstFault;
  wire fsFault;
  wire [31:0] rstLen;

  // ****************************************
  // wake detection
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IO; gi = gi + 1) begin : g_wake
      io_wake_detect #(
        .RESET_LEVEL(1'b0)
      ) u_wake (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pinIn(ioIn[gi]),
        .wakeEn(ioWakeEn[gi]),
        .wakeMode(ioWakeMode[2*gi+1:2*gi]),
        .wakePulse(ioWake[gi])
      );
    end
  endgenerate

  assign anyWake = (canWake & canWakeEn) | (|ioWake);

  // ****************************************
  // safety inputs
  // ****************************************
  // pair must stay complementary
  assign pair01Err = safePair01En & ~(ioIn[0] ^ ioIn[1]);
  assign pair45Err = safePair45En & ~(ioIn[4] ^ ioIn[5]);
  // bi-stable: only io2 high, io3 low is the normal phase
  // judged only while the watchdog runs normally
  assign pair23Err = safePair23En & (fs_r == FS_NORMWD) &
                     ~(ioIn[2] & ~ioIn[3]);
  assign safetyFault = pair01Err | pair45Err | pair23Err |
                       (safeFbEn & fbDeltaOver150mV);

  assign wdFault = wdBadRefresh & ~debug_r;
  assign rstFault = (wdFault | faultToReset) & (fs_r == FS_NORMWD);
  assign fsFault = safetyFault | faultToFailsafe | rstFault;

  // otherwise the configured 1 ms or 10 ms
  assign rstLen = rstLong_r ? RST_LONG_CYC :
                  (durSel_r ? RST_MID_CYC : RST_SHORT_CYC);

  // ****************************************
  // main state machine, next state
  // ****************************************
  always @* begin
    main_nxt = main_r;
    case (main_r)
      M_TOPO: begin
        if (gateAbove120mV || cnt_r >= TOPO_CYC - 1) begin
          main_nxt = M_PRE;
        end
      end
      M_PRE: begin
        if (preSoftDone) begin
          main_nxt = M_SELECT;
        end
      end
      M_SELECT: main_nxt = M_REGON;
      M_REGON: begin
        if (regsRampDone) begin
          main_nxt = M_RSTLOW;
        end
      end
      M_RSTLOW: begin
        if (cnt_r >= rstLen - 1) begin
          main_nxt = M_INIT;
        end
      end
      M_INIT: begin
        if (initIntWr) begin
          main_nxt = M_NORMAL;
        end
      end
      M_NORMAL: begin
        if (sleepCmdSecured) begin
          main_nxt = M_SLEEP;
        end
      end
      M_SLEEP: begin
        if (anyWake) begin
          main_nxt = M_TOPO;
        end
      end
      default: main_nxt = M_TOPO;
    endcase
  end

  // ****************************************
  // main state and phase counter
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      main_r <= M_TOPO;
      cnt_r <= 32'h0;
    end else begin
      main_r <= main_nxt;
      if (main_nxt != main_r) begin
        cnt_r <= 32'h0;
      end else if (main_r == M_TOPO || main_r == M_RSTLOW) begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end

  // ****************************************
  // start-up latches: topology, select, debug
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      buckBoost_r <= 1'b0;
      auxOff_r <= 1'b0;
      debug_r <= 1'b0;
      debugTaken_r <= 1'b0;
    end else begin
      // lock topology at end of detection
      if (main_r == M_TOPO && main_nxt == M_PRE) begin
        buckBoost_r <= gateAbove120mV;
      end
      if (main_r == M_SELECT) begin
        auxOff_r <= selectToPre;
      end
      // never cleared except by power-on reset
      if (main_r == M_PRE && !debugTaken_r) begin
        debug_r <= debugInWindow;
        debugTaken_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // fail-safe state machine
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fs_r <= FS_OFF;
      fsCnt_r <= 32'h0;
      rstLong_r <= 1'b1;
    end else begin
      fsCnt_r <= fsCnt_r + 32'h1;
      case (fs_r)
        // waits for the main sequence to release reset
        FS_OFF: begin
          fsCnt_r <= 32'h0;
          if (main_r == M_INIT) begin
            fs_r <= FS_INIT;
            rstLong_r <= 1'b0;
          end
        end
        // first good refresh inside 256 ms
        FS_INIT: begin
          if (wdGoodRefresh) begin
            fs_r <= FS_NORMWD;
          end else if (fsCnt_r >= INIT_WIN_CYC - 1 && !debug_r) begin
            fs_r <= FS_RSTDLY;
            fsCnt_r <= 32'h0;
          end
        end
        FS_NORMWD: begin
          fsCnt_r <= 32'h0;
          if (rstFault) begin
            fs_r <= FS_RSTDLY;
          end
        end
        // fault reset uses the configured length
        FS_RSTDLY: begin
          if (fsCnt_r >= rstLen - 1) begin
            fs_r <= FS_INIT;
            fsCnt_r <= 32'h0;
          end
        end
        default: fs_r <= FS_OFF;
      endcase
      // sleep and wake restart the fail-safe machine
      if (main_r == M_SLEEP) begin
        fs_r <= FS_OFF;
        rstLong_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // init configuration and lock
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_r <= 1'b0;
      durSel_r <= `RST_DUR_SEL_RESET;
      ampSel_r <= `AMON_REF;
    end else begin
      // init-only write during the init phase
      // after lock the write is dropped
      if (resetDurWr && fs_r == FS_INIT && !lock_r) begin
        durSel_r <= resetDurData;
      end
      if (initIntWr && main_r == M_INIT) begin
        lock_r <= 1'b1;
      end
      // lock is lost only with a fresh sequence after sleep, the config keeps its value
      if (main_r == M_SLEEP) begin
        lock_r <= 1'b0;
      end
      if (ampSelWr) begin
        ampSel_r <= ampSelData;
      end
    end
  end

  // ****************************************
  // fail-safe output control
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fsLow_r <= 1'b1;
      fsReleased_r <= 1'b0;
    end else begin
      // release only after a good watchdog state
      if (fsReleaseWr && fs_r == FS_NORMWD) begin
        fsLow_r <= 1'b0;
        fsReleased_r <= 1'b1;
      end
      // fault asserts; set wins over release
      // in debug, no assert once released
      if (fsFault && !(debug_r && fsReleased_r)) begin
        fsLow_r <= 1'b1;
      end
      if (main_r == M_SLEEP) begin
        fsLow_r <= 1'b1;
        fsReleased_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // wake source record
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wakeSrc_r <= {(NUM_IO+1){1'b0}};
    end else if (main_r == M_SLEEP && anyWake) begin
      // bit 0 is CAN, upper bits the IOs
      wakeSrc_r <= {ioWake, canWake & canWakeEn};
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gateTestEn <= 1'b0;
      preRegEn <= 1'b0;
      coreRegEn <= 1'b0;
      auxRegEn <= 1'b0;
      anaRegEn <= 1'b0;
      xcvrSupplyEn <= 1'b0;
      canForceNormal <= 1'b0;
      analogMonitorSel <= `AMON_REF;
      failsafe_output_n <= 1'b0;
      mcu_reset_n <= 1'b0;
      buckBoost <= 1'b0;
      debugMode <= 1'b0;
      initLocked <= 1'b0;
      resetDurSel <= `RST_DUR_SEL_RESET;
      wakeSource <= {(NUM_IO+1){1'b0}};
      mainState <= M_TOPO;
      fsState <= FS_OFF;
    end else begin
      gateTestEn <= (main_r == M_TOPO);
      preRegEn <= (main_r != M_TOPO) && (main_r != M_SLEEP);
      // the four supplies start in one step
      coreRegEn <= (main_r >= M_REGON) && (main_r != M_SLEEP);
      // aux held off by select strap
      auxRegEn <= (main_r >= M_REGON) && (main_r != M_SLEEP) &&
                  !auxOff_r;
      anaRegEn <= (main_r >= M_REGON) && (main_r != M_SLEEP);
      xcvrSupplyEn <= (main_r >= M_REGON) && (main_r != M_SLEEP);
      canForceNormal <= debug_r;
      analogMonitorSel <= ampSel_r;
      failsafe_output_n <= ~fsLow_r;
      // reset held through start-up and fault delay
      mcu_reset_n <= (main_r == M_INIT || main_r == M_NORMAL) &&
                     (fs_r != FS_RSTDLY);
      buckBoost <= buckBoost_r;
      debugMode <= debug_r;
      initLocked <= lock_r;
      resetDurSel <= durSel_r;
      wakeSource <= wakeSrc_r;
      mainState <= main_r;
      fsState <= fs_r;
    end
  end

endmodule

// ---- power_mode_monitor.sv ----
// Purpose: port checks of the power mode sequencer
// Assumes: state codes and output timing of the hand-over
// Notes: attached to every sequencer instance by bind
`timescale 1ns/1ps

module power_mode_monitor #(
  parameter int NUM_IO = 6
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // requests
  input wire logic selectToPre,
  input wire logic initIntWr,
  input wire logic sleepCmdSecured,
  input wire logic wdBadRefresh,
  input wire logic resetDurWr,
  input wire logic faultToFailsafe,
  input wire logic faultToReset,
  // supplies
  input wire logic coreRegEn,
  input wire logic auxRegEn,
  input wire logic anaRegEn,
  input wire logic xcvrSupplyEn,
  // pins and status
  input wire logic canForceNormal,
  input wire logic failsafe_output_n,
  input wire logic mcu_reset_n,
  input wire logic debugMode,
  input wire logic initLocked,
  input wire logic resetDurSel,
  input wire logic [NUM_IO:0] wakeSource,
  input wire logic [3:0] mainState
);
  // ****************************************
  // sequences
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // three calm debug cycles, so a sleep entry is not taken for a fault
  sequence dbgQuiet;
    (debugMode && !sleepCmdSecured)[*3];
  endsequence
  // no reset fault or sleep in flight
  sequence calmPair;
    (!faultToReset && !sleepCmdSecured)[*2];
  endsequence
  sequence sleepToTopo;
    mainState == 4'h7 ##1 mainState == 4'h0;
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  a_fs_low_start: assert property (mainState == 4'h0 |-> !failsafe_output_n)
    else $error("fail-safe output high during topology detection");
  a_regs_together: assert property ($rose(coreRegEn) |-> $rose(anaRegEn) && $rose(xcvrSupplyEn))
    else $error("supplies did not start together");
  a_aux_held_off: assert property ($rose(coreRegEn) && selectToPre |-> !auxRegEn)
    else $error("aux regulator on with select tied to pre-regulator");
  a_fault_fs_low: assert property (faultToFailsafe && !debugMode |-> ##[1:3] !failsafe_output_n)
    else $error("fault did not pull fail-safe output low");
  a_debug_fs_kept: assert property (dbgQuiet ##0 failsafe_output_n |=> failsafe_output_n)
    else $error("fail-safe output asserted again in debug mode");
  a_debug_no_reset: assert property (debugMode && wdBadRefresh && mcu_reset_n ##0 calmPair |=> mcu_reset_n)
    else $error("watchdog error reset the MCU in debug mode");
  a_debug_can_normal: assert property (debugMode [*2] |-> canForceNormal)
    else $error("transceiver not forced normal in debug mode");
  a_init_lock: assert property (initIntWr && mainState == 4'h5 |-> ##[1:2] (initLocked && mainState == 4'h6))
    else $error("init-complete write did not lock and enter normal");
  a_locked_dur: assert property (resetDurWr && initLocked ##1 !resetDurWr |=> $stable(resetDurSel))
    else $error("locked reset duration changed");
  a_sleep_off: assert property (mainState == 4'h7 && $past(mainState) == 4'h7 |-> !(coreRegEn || auxRegEn || anaRegEn || xcvrSupplyEn))
    else $error("regulator on during sleep");
  a_sleep_entry: assert property (mainState == 4'h7 && $past(mainState) != 4'h7 |-> $past(mainState) == 4'h6)
    else $error("sleep entered from a mode other than normal");
  a_wake_source: assert property (sleepToTopo |-> ##[0:1] (|wakeSource))
    else $error("wake without a recorded source");
endmodule

bind power_mode_sequencer power_mode_monitor #(.NUM_IO(NUM_IO)) mon (.*);

// ---- mcu_model.sv ----
// Purpose: host microcontroller model for the sequencer
// Assumes: device samples commands on the rising clock edge
// Notes: only the sleep request path lives here
`timescale 1ns/1ps

module mcu_model #(
  parameter int ERR_LIMIT = 2,
  parameter int REFRESH_CNT = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // device pins and commands
  input wire logic mcu_reset_n,
  output logic wdGoodRefresh,
  output logic sleepCmdSecured,
  // bench control
  input wire logic sleepReq,
  input wire logic [3:0] gapIn,
  output logic sleepDone
);
  localparam int N = ERR_LIMIT * (REFRESH_CNT + 1);
  logic active_r;
  logic [3:0] gapCnt_r;
  int sentCnt_r;

  // ****************************************
  // sleep request
  // ****************************************
  // clear error counter
  // a cpu held in reset sends nothing, so the run pauses meanwhile
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_r <= 1'b0;
      gapCnt_r <= 4'h0;
      sentCnt_r <= 0;
      wdGoodRefresh <= 1'b0;
      sleepCmdSecured <= 1'b0;
      sleepDone <= 1'b0;
    end else begin
      wdGoodRefresh <= 1'b0;
      sleepCmdSecured <= 1'b0;
      if (sleepReq) begin
        active_r <= 1'b1;
        sentCnt_r <= 0;
        gapCnt_r <= gapIn;
        sleepDone <= 1'b0;
      end else if (active_r && mcu_reset_n) begin
        if (gapCnt_r != 4'h0) begin
          gapCnt_r <= gapCnt_r - 4'h1;
        end else if (sentCnt_r < N) begin
          wdGoodRefresh <= 1'b1;
          sentCnt_r <= sentCnt_r + 1;
          gapCnt_r <= gapIn;
        end else begin
          sleepCmdSecured <= 1'b1;
          active_r <= 1'b0;
          sleepDone <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench of the power mode sequencer
// Assumes: short counts set by parameter, host model for sleep
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`include "power_mode_map.vh"

module testbench;
  localparam int RSHORT = 10;
  localparam int RMID = 20;
  localparam int RLONG = 40;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic gateAbove120mV = 1'b0;
  logic preSoftDone = 1'b0;
  logic selectToPre = 1'b0;
  logic regsRampDone = 1'b0;
  logic debugInWindow = 1'b0;
  logic fbDeltaOver150mV = 1'b0;
  logic [5:0] ioIn = 6'h26;
  logic canWake = 1'b0;
  logic ampSelWr = 1'b0;
  logic ampSelData = 1'b0;
  logic resetDurWr = 1'b0;
  logic resetDurData = 1'b0;
  logic initIntWr = 1'b0;
  logic fsReleaseWr = 1'b0;
  logic tbGood = 1'b0;
  logic wdBadRefresh = 1'b0;
  logic faultToFailsafe = 1'b0;
  logic faultToReset = 1'b0;
  logic [5:0] ioWakeEn = 6'h00;
  logic [11:0] ioWakeMode = 12'hfff;
  logic canWakeEn = 1'b0;
  logic safePair01En = 1'b0;
  logic safePair45En = 1'b0;
  logic safeFbEn = 1'b0;
  logic safePair23En = 1'b0;
  logic sleepReq = 1'b0;
  logic [3:0] gapIn = 4'h0;
  logic mdlGood, sleepCmdSecured, sleepDone, gateTestEn, preRegEn;
  logic coreRegEn, auxRegEn, anaRegEn, xcvrSupplyEn, canForceNormal;
  logic analogMonitorSel, failsafe_output_n, mcu_reset_n, buckBoost;
  logic debugMode, initLocked, resetDurSel;
  logic [6:0] wakeSource;
  logic [3:0] mainState;
  logic [1:0] fsState;
  int nMismatch = 0;
  int samplesChecked = 0;
  int lowCnt;

  // ****************************************
  // clock, design and host
  // ****************************************
  always #2.5 core_clk = ~core_clk;

  power_mode_sequencer #(.NUM_IO(6), .TOPO_CYC(8), .RST_SHORT_CYC(RSHORT),
    .RST_MID_CYC(RMID), .RST_LONG_CYC(RLONG), .INIT_WIN_CYC(400))
    dut (.wdGoodRefresh(tbGood | mdlGood), .*);
  mcu_model host (.wdGoodRefresh(mdlGood), .*);

  // ****************************************
  // tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one command strobe, then a quiet cycle
  task automatic spi(input int k, input logic d);
    ampSelData = d;
    resetDurData = d;
    case (k)
      0: ampSelWr = 1'b1;
      1: resetDurWr = 1'b1;
      2: initIntWr = 1'b1;
      3: fsReleaseWr = 1'b1;
      4: tbGood = 1'b1;
      default: wdBadRefresh = 1'b1;
    endcase
    tick(1);
    {ampSelWr, resetDurWr, initIntWr, fsReleaseWr, tbGood, wdBadRefresh} = '0;
    tick(1);
  endtask

  task automatic por(input logic dbg, input logic sel);
    rst_b = 1'b0;
    debugInWindow = dbg;
    selectToPre = sel;
    {gateAbove120mV, preSoftDone, regsRampDone} = 3'h0;
    tick(6);
    rst_b = 1'b1;
  endtask

  // optional reset fault strobe, then the length of the reset-low span
  task automatic lowSpan(input logic strobe, input int len);
    faultToReset = strobe;
    for (int i = 0; i < 500 && mcu_reset_n === 1'b1; i++) begin
      tick(1);
      faultToReset = 1'b0;
    end
    lowCnt = 0;
    for (int i = 0; i < 200 && mcu_reset_n !== 1'b1; i++) begin
      lowCnt++;
      tick(1);
    end
    check("reset low", 1,
          lowCnt >= len - 2 && lowCnt <= len + 4);
  endtask

  task automatic boot(input logic bb);
    lowCnt = 0;
    gateAbove120mV = bb;
    preSoftDone = 1'b1;
    regsRampDone = 1'b1;
    for (int i = 0; i < 400 && mainState !== 4'h5; i++) begin
      if (coreRegEn === 1'b1 && mcu_reset_n === 1'b0) lowCnt++;
      tick(1);
    end
    tick(2);
    check("buckBoost", bb, buckBoost);
    check("long reset", 1, lowCnt >= RLONG && lowCnt <= RLONG + 6);
    check("supplies", {3'h7, ~selectToPre, 2'h2},
          {coreRegEn, anaRegEn, xcvrSupplyEn, auxRegEn, preRegEn,
           gateTestEn});
    check("reset released", 1, mcu_reset_n);
    check("fs after start", 0, failsafe_output_n);
    $display("test boot done");
  endtask

  task automatic initRun(input logic dur);
    spi(1, dur);
    spi(0, 1'b1);
    check("monitor temp", `AMON_TEMP, analogMonitorSel);
    spi(0, 1'b0);
    spi(4, 1'b0);
    spi(2, 1'b0);
    tick(1);
    check("monitor ref", `AMON_REF, analogMonitorSel);
    check("lock", {5'h16, 2'h1}, {initLocked, mainState, fsState});
    spi(1, ~dur);
    spi(3, 1'b0);
    tick(1);
    check("duration", dur, resetDurSel);
    check("fs released", 1, failsafe_output_n);
    $display("test init done");
  endtask

  task automatic finalReport;
    $display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    por(1'b0, 1'b0);
    boot(1'b1);
    check("no debug", 0, debugMode);
    initRun(1'b1);
    // each fault source in turn, fail-safe released before each
    {safePair01En, safePair45En, safeFbEn, safePair23En} = 4'hf;
    for (int k = 0; k < 5; k++) begin
      spi(3, 1'b0);
      tick(1);
      check("fs release", 1, failsafe_output_n);
      case (k)
        0: faultToFailsafe = 1'b1;
        1: ioIn[1] = 1'b0;
        2: ioIn[5] = 1'b0;
        3: fbDeltaOver150mV = 1'b1;
        default: ioIn[2] = 1'b0;
      endcase
      tick(4);
      check("fs fault", 0, failsafe_output_n);
      {faultToFailsafe, fbDeltaOver150mV} = 2'h0;
      ioIn = 6'h26;
      tick(2);
    end
    {safePair01En, safePair45En, safeFbEn, safePair23En} = 4'h0;
    $display("test faults done");
    lowSpan(1'b1, RMID);
    // no refresh in the init window, so the window runs out into a reset
    lowSpan(1'b0, RMID);
    spi(4, 1'b0);
    tick(1);
    check("fs normal", 2'h1, fsState);
    $display("test fault reset done");
    // sleep and wake from io0, io1, io2 (one edge mode each) and CAN
    for (int m = 0; m < 4; m++) begin
      gateAbove120mV = 1'b0;
      ioIn = (m == 1) ? 6'h02 : 6'h00;
      ioWakeEn = (m < 3) ? (6'h01 << m) : 6'h00;
      ioWakeMode = ~(12'h3 << (2 * m)) | (12'(m) << (2 * m));
      canWakeEn = (m == 3);
      gapIn = 4'(m * 2);
      sleepReq = 1'b1;
      tick(1);
      sleepReq = 1'b0;
      for (int i = 0; i < 300 && sleepDone !== 1'b1; i++) tick(1);
      tick(4);
      check("sleep", {4'h7, 7'h0}, {mainState, coreRegEn, auxRegEn,
            anaRegEn, xcvrSupplyEn, preRegEn, gateTestEn,
            failsafe_output_n});
      if (m == 3) canWake = 1'b1;
      else ioIn[m] = (m != 1);
      for (int i = 0; i < 50 && mainState !== 4'h0; i++) tick(1);
      tick(2);
      check("wake source", (m == 3) ? 7'h01 : (7'h02 << m), wakeSource);
      check("topology test", 2'h2, {gateTestEn, preRegEn});
      canWake = 1'b0;
      boot(1'b0);
      initRun(1'b0);
    end
    $display("test sleep done");
    por(1'b1, 1'b1);
    boot(1'b1);
    check("debug", 2'h3, {debugMode, canForceNormal});
    initRun(1'b0);
    faultToFailsafe = 1'b1;
    spi(5, 1'b0);
    tick(4);
    check("debug pins", 2'h3, {failsafe_output_n, mcu_reset_n});
    faultToFailsafe = 1'b0;
    lowSpan(1'b1, RSHORT);
    check("debug fs kept", 1, failsafe_output_n);
    $display("test debug done");
    finalReport();
  end

  // hang guard, far beyond the expected run
  initial begin
    #200000;
    nMismatch++;
    $display("unexpected run length: expected end seen hang");
    finalReport();
  end
endmodule
